// [verilog/lal_pkg.sv]
// constants shared by the load analyzer logger
package lal_pkg;
  localparam int DATA_W = 16;
  localparam int FRAC_W = 8;
  localparam int CNT_W = 32;
  localparam int NCLASS = 10;
  localparam int CLASS_W = 4;
  localparam int DATE_W = 16;
  localparam int TOD_W = 17;
  localparam int DI_NUM = 6;
  localparam int FULL_PCT = 100;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PEAK_PERIOD_MS = 2;
  localparam int DIST_PERIOD_MS = 200;
  localparam int SEC_MS = 1000;
  localparam int DAY_SEC = 86400;
  localparam int FILT_LSB_MS = 100;
  localparam int FILT_DIV = FILT_LSB_MS / PEAK_PERIOD_MS;
  localparam logic [10:0] FILT_MAX = 11'h4b0;
  localparam logic [10:0] FILT_RST = 11'h000;
  localparam logic [7:0] SEL_NONE = 8'h64;
  localparam logic [7:0] SRC_NONE = 8'h00;
  localparam logic [7:0] SRC_CLEAR = 8'h07;
  localparam logic [15:0] BASE_RST = 16'h0064;
  localparam logic [7:0] A_PEAK_SEL = 8'h00;
  localparam logic [7:0] A_FILT = 8'h01;
  localparam logic [7:0] A_SRC = 8'h02;
  localparam logic [7:0] A_DIST_SEL = 8'h03;
  localparam logic [7:0] A_BASE = 8'h04;
  localparam logic [7:0] A_PEAK = 8'h05;
  localparam logic [7:0] A_PEAK_DATE = 8'h06;
  localparam logic [7:0] A_PEAK_TIME = 8'h07;
  localparam logic [7:0] A_CUR_PK = 8'h08;
  localparam logic [7:0] A_UDC_PK = 8'h09;
  localparam logic [7:0] A_FREQ_PK = 8'h0a;
  localparam logic [7:0] A_RST_DATE = 8'h0b;
  localparam logic [7:0] A_RST_TIME = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h0d;
  localparam logic [3:0] PAGE_AL1 = 4'h1;
  localparam logic [3:0] PAGE_AL2 = 4'h2;
endpackage : lal_pkg

// [verilog/lal_dist.sv]
// ten-class amplitude distribution counter
`timescale 1ns/10ps
module lal_dist (
  input wire logic i_clk, // clock
  input wire logic i_rst, // sync reset
  input wire logic i_clear, // clear all classes
  input wire logic i_sample, // take one sample
  input wire logic signed [lal_pkg::DATA_W-1:0] i_value, // sample
  input wire logic [lal_pkg::DATA_W-1:0] i_base, // 100 percent level
  input wire logic [lal_pkg::CLASS_W-1:0] i_rd_class, // class to show
  output logic [lal_pkg::CNT_W-1:0] o_count, // samples in class
  output logic [lal_pkg::CNT_W-1:0] o_total // samples since clear
);
  localparam int PW = lal_pkg::DATA_W + lal_pkg::CLASS_W;
  logic [lal_pkg::CNT_W-1:0] cnt_reg [lal_pkg::NCLASS];
  logic [lal_pkg::CNT_W-1:0] total_reg;
  logic [lal_pkg::CLASS_W-1:0] cls;

  // negative values land in the lowest class, overflow and any value with a zero base in the top one
  function automatic logic [lal_pkg::CLASS_W-1:0] class_of(
    input logic signed [lal_pkg::DATA_W-1:0] v,
    input logic [lal_pkg::DATA_W-1:0] b);
    logic [PW-1:0] q;
    q = '0;
    if (b == '0) begin
      q = PW'(lal_pkg::NCLASS - 1);
    end else if (!v[lal_pkg::DATA_W-1]) begin
      q = (PW'(v) * PW'(lal_pkg::NCLASS)) / PW'(b);
    end
    if (q > PW'(lal_pkg::NCLASS - 1)) begin
      q = PW'(lal_pkg::NCLASS - 1);
    end
    return q[lal_pkg::CLASS_W-1:0];
  endfunction : class_of

  assign cls = class_of(i_value, i_base);

  genvar g;
  generate
    for (g = 0; g < lal_pkg::NCLASS; g++) begin : g_cls
      always_ff @(posedge i_clk) begin
        if (i_rst || i_clear) begin
          cnt_reg[g] <= '0;
        end else if (i_sample && cls == lal_pkg::CLASS_W'(g)) begin
          cnt_reg[g] <= cnt_reg[g] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      total_reg <= '0;
    end else if (i_sample) begin
      total_reg <= total_reg + 1'b1;
    end
  end

  always_comb begin
    o_count = '0;
    if (i_rd_class < lal_pkg::CLASS_W'(lal_pkg::NCLASS)) begin
      o_count = cnt_reg[i_rd_class];
    end
  end
  assign o_total = total_reg;
endmodule : lal_dist

// [verilog/lal_top.sv]
// load analyzer: peak logger and two amplitude distribution loggers
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
module lal_top #(
  parameter int P_MS_CYCLES = lal_pkg::MS_CYCLES
) (
  input wire logic i_clk, // 125 MHz clock
  input wire logic i_rst, // sync reset, high
  input wire logic [7:0] i_addr, // register word address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic [lal_pkg::DI_NUM-1:0] i_din, // digital input pins
  input wire logic signed [lal_pkg::DATA_W-1:0] i_peak_value, // selected
  input wire logic signed [lal_pkg::DATA_W-1:0] i_dist_value, // selected
  input wire logic signed [lal_pkg::DATA_W-1:0] i_current, // motor current
  input wire logic signed [lal_pkg::DATA_W-1:0] i_udc, // dc link voltage
  input wire logic signed [lal_pkg::DATA_W-1:0] i_freq, // output frequency
  input wire logic [lal_pkg::DATA_W-1:0] i_nom_current, // nominal current
  input wire logic i_rtc_valid, // real-time clock running
  input wire logic [lal_pkg::DATE_W-1:0] i_rtc_date, // rtc date
  input wire logic [lal_pkg::TOD_W-1:0] i_rtc_time, // rtc second of day
  output logic [7:0] o_peak_index, // data item for i_peak_value
  output logic [7:0] o_dist_index // data item for i_dist_value
);
  localparam int DW = lal_pkg::DATA_W;
  localparam int FW = lal_pkg::DATA_W + lal_pkg::FRAC_W + 2;
  localparam int MW = $clog2(P_MS_CYCLES + 1);

  // time base
  logic [MW-1:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic [1:0] pk_cnt_reg;
  logic peak_tick_reg;
  logic [7:0] ds_cnt_reg;
  logic dist_tick_reg;
  logic [9:0] sec_cnt_reg;
  logic [lal_pkg::TOD_W-1:0] sod_reg;
  logic [lal_pkg::DATE_W-1:0] day_reg;
  always_ff @(posedge i_clk) begin
    ms_tick_reg <= !i_rst && ms_cnt_reg == MW'(P_MS_CYCLES - 1);
    if (i_rst || ms_cnt_reg == MW'(P_MS_CYCLES - 1)) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pk_cnt_reg <= '0;
      peak_tick_reg <= 1'b0;
    end else begin
      peak_tick_reg <= 1'b0;
      if (ms_tick_reg) begin
        if (pk_cnt_reg == 2'(lal_pkg::PEAK_PERIOD_MS - 1)) begin
          pk_cnt_reg <= '0;
          peak_tick_reg <= 1'b1;
        end else begin
          pk_cnt_reg <= pk_cnt_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ds_cnt_reg <= '0;
      dist_tick_reg <= 1'b0;
    end else begin
      dist_tick_reg <= 1'b0;
      if (ms_tick_reg) begin
        if (ds_cnt_reg == 8'(lal_pkg::DIST_PERIOD_MS - 1)) begin
          ds_cnt_reg <= '0;
          dist_tick_reg <= 1'b1;
        end else begin
          ds_cnt_reg <= ds_cnt_reg + 1'b1;
        end
      end
    end
  end
  // uptime as days plus second of day
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sec_cnt_reg <= '0;
      sod_reg <= '0;
      day_reg <= '0;
    end else if (ms_tick_reg) begin
      if (sec_cnt_reg == 10'(lal_pkg::SEC_MS - 1)) begin
        sec_cnt_reg <= '0;
        if (sod_reg == lal_pkg::TOD_W'(lal_pkg::DAY_SEC - 1)) begin
          sod_reg <= '0;
          day_reg <= day_reg + 1'b1;
        end else begin
          sod_reg <= sod_reg + 1'b1;
        end
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 1'b1;
      end
    end
  end

  logic [lal_pkg::DATE_W-1:0] stamp_date;
  logic [lal_pkg::TOD_W-1:0] stamp_time;
  assign stamp_date = i_rtc_valid ? i_rtc_date : day_reg;
  assign stamp_time = i_rtc_valid ? i_rtc_time : sod_reg;
  // digital inputs: two-stage sync, then edge detect on the second stage
  logic [lal_pkg::DI_NUM-1:0] din_s1_reg, din_s2_reg, din_d_reg;
  logic [lal_pkg::DI_NUM-1:0] din_rise, din_fall;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      din_d_reg <= '0;
    end else begin
      din_s1_reg <= i_din;
      din_s2_reg <= din_s1_reg;
      din_d_reg <= din_s2_reg;
    end
  end
  assign din_rise = din_s2_reg & ~din_d_reg;
  assign din_fall = ~din_s2_reg & din_d_reg;

  function automatic logic src_hit(input logic signed [7:0] s,
    input logic [lal_pkg::DI_NUM-1:0] r, input logic [lal_pkg::DI_NUM-1:0] f);
    logic hit;
    hit = 1'b0;
    for (int k = 1; k <= lal_pkg::DI_NUM; k++) begin
      if (s == 8'(k)) begin
        hit = r[k-1];
      end
      if (s == -8'(k)) begin
        hit = f[k-1];
      end
    end
    return hit;
  endfunction : src_hit
  // configuration
  logic [7:0] peak_sel_reg, dist_sel_reg, src_reg;
  logic [10:0] filt_time_reg;
  logic [DW-1:0] base_reg;
  logic [10:0] filt_wr;
  logic wr_psel, wr_dsel, wr_filt, wr_src, cfg_change, clr;
  assign wr_psel = i_wr && i_addr == lal_pkg::A_PEAK_SEL;
  assign wr_dsel = i_wr && i_addr == lal_pkg::A_DIST_SEL;
  assign wr_filt = i_wr && i_addr == lal_pkg::A_FILT;
  assign wr_src = i_wr && i_addr == lal_pkg::A_SRC;
  assign filt_wr = (i_wdata > 32'(lal_pkg::FILT_MAX)) ? lal_pkg::FILT_MAX
                                                      : i_wdata[10:0];
  assign cfg_change = (wr_psel && i_wdata[7:0] != peak_sel_reg) ||
                      (wr_dsel && i_wdata[7:0] != dist_sel_reg) ||
                      (wr_filt && filt_wr != filt_time_reg);
  assign clr = cfg_change ||
               (wr_src && i_wdata[7:0] == lal_pkg::SRC_CLEAR) ||
               src_hit(src_reg, din_rise, din_fall);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      peak_sel_reg <= lal_pkg::SEL_NONE;
      dist_sel_reg <= lal_pkg::SEL_NONE;
      filt_time_reg <= lal_pkg::FILT_RST;
      base_reg <= lal_pkg::BASE_RST;
    end else begin
      if (wr_psel) peak_sel_reg <= i_wdata[7:0];
      if (wr_dsel) dist_sel_reg <= i_wdata[7:0];
      if (wr_filt) filt_time_reg <= filt_wr;
      if (i_wr && i_addr == lal_pkg::A_BASE) base_reg <= i_wdata[DW-1:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_reg <= lal_pkg::SRC_NONE;
    end else if (wr_src) begin
      src_reg <= (i_wdata[7:0] == lal_pkg::SRC_CLEAR) ? lal_pkg::SRC_NONE
                                                      : i_wdata[7:0];
    end
  end
  assign o_peak_index = peak_sel_reg;
  assign o_dist_index = dist_sel_reg;

  // first-order low-pass, step = (x - y) * 2 ms / tau
  logic signed [FW-1:0] filt_reg, x_fix, den;
  logic filt_valid_reg, filt_upd_reg, peak_on;
  assign peak_on = peak_sel_reg != lal_pkg::SEL_NONE;
  assign x_fix = FW'(i_peak_value) <<< lal_pkg::FRAC_W;
  assign den = FW'(lal_pkg::FILT_DIV * int'(filt_time_reg));
  always_ff @(posedge i_clk) begin
    if (i_rst || clr) begin
      filt_reg <= '0;
      filt_valid_reg <= 1'b0;
      filt_upd_reg <= 1'b0;
    end else begin
      filt_upd_reg <= peak_tick_reg && peak_on;
      if (peak_tick_reg && peak_on) begin
        filt_valid_reg <= 1'b1;
        if (!filt_valid_reg || filt_time_reg == '0) begin
          filt_reg <= x_fix;
        end else begin
          filt_reg <= filt_reg + (x_fix - filt_reg) / den;
        end
      end
    end
  end
  // peak capture on the cycle after a filter update
  logic signed [DW-1:0] filt_y, peak_reg, cur_pk_reg, udc_pk_reg, frq_pk_reg;
  logic peak_valid_reg, new_peak;
  logic [lal_pkg::DATE_W-1:0] pk_date_reg, rst_date_reg;
  logic [lal_pkg::TOD_W-1:0] pk_time_reg, rst_time_reg;
  assign filt_y = filt_reg[lal_pkg::FRAC_W +: DW];
  assign new_peak = filt_upd_reg && (!peak_valid_reg || filt_y > peak_reg);
  always_ff @(posedge i_clk) begin
    if (i_rst || clr) begin
      peak_valid_reg <= 1'b0;
      peak_reg <= '0;
      cur_pk_reg <= '0;
      udc_pk_reg <= '0;
      frq_pk_reg <= '0;
      pk_date_reg <= '0;
      pk_time_reg <= '0;
    end else if (new_peak) begin
      peak_valid_reg <= 1'b1;
      peak_reg <= filt_y;
      cur_pk_reg <= i_current;
      udc_pk_reg <= i_udc;
      frq_pk_reg <= i_freq;
      pk_date_reg <= stamp_date;
      pk_time_reg <= stamp_time;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rst_date_reg <= '0;
      rst_time_reg <= '0;
    end else if (clr) begin
      rst_date_reg <= stamp_date;
      rst_time_reg <= stamp_time;
    end
  end

  // distributions
  logic [lal_pkg::CNT_W-1:0] al1_cnt, al1_tot, al2_cnt, al2_tot;
  logic al2_sample;
  assign al2_sample = dist_tick_reg && dist_sel_reg != lal_pkg::SEL_NONE;
  lal_dist u_al1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(1'b0),
    .i_sample(dist_tick_reg),
    .i_value(i_current),
    .i_base(i_nom_current),
    .i_rd_class(i_addr[3:0]),
    .o_count(al1_cnt),
    .o_total(al1_tot)
  );
  lal_dist u_al2 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(clr),
    .i_sample(al2_sample),
    .i_value(i_dist_value),
    .i_base(base_reg),
    .i_rd_class(i_addr[3:0]),
    .o_count(al2_cnt),
    .o_total(al2_tot)
  );

  function automatic logic [31:0] pct(input logic [31:0] c,
    input logic [31:0] t);
    logic [38:0] p;
    p = '0;
    if (t != '0) begin
      p = ({7'h00, c} * 39'(lal_pkg::FULL_PCT)) / {7'h00, t};
    end
    return p[31:0];
  endfunction : pct
  // register read, data valid the cycle after the strobe
  logic in_class;
  assign in_class = i_addr[3:0] < 4'(lal_pkg::NCLASS);
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_rd) begin
      o_rdata <= '0;
    end else begin
      case (i_addr)
        lal_pkg::A_PEAK_SEL: o_rdata <= 32'(peak_sel_reg);
        lal_pkg::A_FILT: o_rdata <= 32'(filt_time_reg);
        lal_pkg::A_SRC: o_rdata <= 32'(signed'(src_reg));
        lal_pkg::A_DIST_SEL: o_rdata <= 32'(dist_sel_reg);
        lal_pkg::A_BASE: o_rdata <= 32'(base_reg);
        lal_pkg::A_PEAK: o_rdata <= 32'(peak_reg);
        lal_pkg::A_PEAK_DATE: o_rdata <= 32'(pk_date_reg);
        lal_pkg::A_PEAK_TIME: o_rdata <= 32'(pk_time_reg);
        lal_pkg::A_CUR_PK: o_rdata <= 32'(cur_pk_reg);
        lal_pkg::A_UDC_PK: o_rdata <= 32'(udc_pk_reg);
        lal_pkg::A_FREQ_PK: o_rdata <= 32'(frq_pk_reg);
        lal_pkg::A_RST_DATE: o_rdata <= 32'(rst_date_reg);
        lal_pkg::A_RST_TIME: o_rdata <= 32'(rst_time_reg);
        lal_pkg::A_STATUS: o_rdata <= {30'h0, i_rtc_valid, peak_valid_reg};
        default: begin
          if (i_addr[7:4] == lal_pkg::PAGE_AL1 && in_class) begin
            o_rdata <= pct(al1_cnt, al1_tot);
          end else if (i_addr[7:4] == lal_pkg::PAGE_AL2 && in_class) begin
            o_rdata <= pct(al2_cnt, al2_tot);
          end else begin
            o_rdata <= '0;
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_peak_sample; peak_tick_reg && peak_on; endsequence
  sequence s_new_peak; s_peak_sample ##1 (new_peak && !clr); endsequence
  AST_PEAK_HOLD: assert property (
    peak_valid_reg && !clr && !new_peak |=> $stable(peak_reg))
    else $error("peak changed without a new peak");
  AST_PEAK_LATCH: assert property (
    s_new_peak |=> peak_reg == $past(filt_y) &&
      cur_pk_reg == $past(i_current) && frq_pk_reg == $past(i_freq))
    else $error("peak capture lost its context");
  AST_DIST_STEP: assert property (
    dist_tick_reg |=> al1_tot == $past(al1_tot) + 32'h1)
    else $error("logger one missed a 200 ms sample");
  AST_AL1_KEEP: assert property (
    clr && !dist_tick_reg |=> al1_tot == $past(al1_tot))
    else $error("logger one was cleared");
  AST_CFG_CLEAR: assert property (
    cfg_change |=> !peak_valid_reg && al2_tot == 32'h0)
    else $error("setting change did not clear the loggers");
  AST_PEAK_OFF: assert property (
    peak_tick_reg && !peak_on |=> !filt_upd_reg ##1 !new_peak)
    else $error("peak logged with no signal selected");
  AST_FILT_MAX: assert property (
    wr_filt |=> filt_time_reg <= lal_pkg::FILT_MAX)
    else $error("filter time above its limit");
  AST_SRC_EDGE: assert property (
    src_reg == 8'h01 && din_rise[0] |=> !peak_valid_reg)
    else $error("input edge did not clear the loggers");
  AST_SRC_REVERT: assert property (
    wr_src && i_wdata[7:0] == lal_pkg::SRC_CLEAR |=>
      src_reg == lal_pkg::SRC_NONE && !peak_valid_reg)
    else $error("clear command did not revert the source");
  AST_AL2_IDLE: assert property (
    dist_tick_reg && dist_sel_reg == lal_pkg::SEL_NONE && !clr |=>
      $stable(al2_tot))
    else $error("logger two sampled with no signal");
  AST_RST_STAMP: assert property (
    clr && !i_rtc_valid |=> rst_date_reg == $past(day_reg) &&
      rst_time_reg == $past(sod_reg))
    else $error("clear time not recorded");
endmodule : lal_top

// [verif/lal_drive_model.sv]
// drive side model: measurement signals and digital input pins
`timescale 1ns/10ps
module lal_drive_model (
  input wire logic i_clk, // clock
  input wire logic [7:0] i_peak_index, // item asked for on peak value
  input wire logic [7:0] i_dist_index, // item asked for on dist value
  input wire logic signed [15:0] i_peak_level, // level of peak item
  input wire logic signed [15:0] i_dist_level, // level of dist item
  input wire logic signed [15:0] i_cur_level, // motor current level
  input wire logic [5:0] i_din_level, // wanted pin levels
  output logic signed [15:0] o_peak_value, // peak item value
  output logic signed [15:0] o_dist_value, // dist item value
  output logic signed [15:0] o_current, // motor current
  output logic signed [15:0] o_udc, // dc link voltage
  output logic signed [15:0] o_freq, // output frequency
  output logic [5:0] o_din // digital input pins
);
  logic [15:0] junk_reg = 16'h5a5a;

  // no item selected: the value wanders instead of holding still
  always_ff @(posedge i_clk) begin
    junk_reg <= ~junk_reg + 16'h0013;
  end

  assign o_peak_value = (i_peak_index == lal_pkg::SEL_NONE) ?
    $signed(junk_reg) : i_peak_level;
  assign o_dist_value = (i_dist_index == lal_pkg::SEL_NONE) ?
    $signed(~junk_reg) : i_dist_level;
  assign o_current = i_cur_level;
  assign o_udc = i_cur_level + 16'sh0200;
  assign o_freq = i_peak_level >>> 2;
  assign o_din = i_din_level;
endmodule : lal_drive_model

// [verif/testbench.sv]
// self-checking bench for the load analyzer logger
`timescale 1ns/10ps
module testbench;
  localparam int MSC = 10;
  localparam int PK_CYC = 2 * MSC;
  localparam int DS_CYC = 200 * MSC;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [5:0] din_set = 6'h00;
  logic [5:0] din;
  logic signed [15:0] pk_lvl = 16'sh0000;
  logic signed [15:0] ds_lvl = 16'sh0000;
  logic signed [15:0] cur_lvl = 16'sh0023;
  logic [15:0] nom_cur = 16'h0030;
  logic signed [15:0] pk_val, ds_val, cur, udc, frq;
  logic rtc_ok = 1'b0;
  logic [15:0] rtc_date = 16'h1234;
  logic [16:0] rtc_time = 17'h00abc;
  logic [7:0] pk_idx, ds_idx;
  logic [31:0] rd_val;
  int err_total = 0;
  int n_compared = 0;

  always #4 i_clk = ~i_clk;

  lal_top #(.P_MS_CYCLES(MSC)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_din(din),
    .i_peak_value(pk_val), .i_dist_value(ds_val), .i_current(cur),
    .i_udc(udc), .i_freq(frq), .i_nom_current(nom_cur),
    .i_rtc_valid(rtc_ok), .i_rtc_date(rtc_date), .i_rtc_time(rtc_time),
    .o_peak_index(pk_idx), .o_dist_index(ds_idx));

  lal_drive_model i_drive (
    .i_clk(i_clk), .i_peak_index(pk_idx), .i_dist_index(ds_idx),
    .i_peak_level(pk_lvl), .i_dist_level(ds_lvl), .i_cur_level(cur_lvl),
    .i_din_level(din_set), .o_peak_value(pk_val), .o_dist_value(ds_val),
    .o_current(cur), .o_udc(udc), .o_freq(frq), .o_din(din));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_cyc

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_clk);
  endtask : reg_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_rd(a, rd_val);
    check(rd_val, exp);
  endtask : rd_chk

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic t_reset();
    check({24'h0, pk_idx}, 32'h64);
    check({24'h0, ds_idx}, 32'h64);
    rd_chk(lal_pkg::A_PEAK_SEL, 32'h64);
    rd_chk(lal_pkg::A_DIST_SEL, 32'h64);
    rd_chk(lal_pkg::A_FILT, 32'h0);
    rd_chk(lal_pkg::A_SRC, 32'h0);
    rd_chk(8'hff, 32'h0);
  endtask : t_reset

  task automatic t_peak();
    reg_wr(lal_pkg::A_PEAK_SEL, 32'h65);
    pk_lvl <= 16'sh0032;
    rtc_ok <= 1'b1;
    wait_cyc(3 * PK_CYC);
    check({24'h0, pk_idx}, 32'h65);
    rd_chk(lal_pkg::A_PEAK, 32'h32);
    pk_lvl <= 16'sh00c8;
    rtc_time <= 17'h00321;
    wait_cyc(3 * PK_CYC);
    rd_chk(lal_pkg::A_PEAK, 32'hc8);
    pk_lvl <= 16'sh0064;
    cur_lvl <= 16'sh0024;
    rtc_time <= 17'h00322;
    wait_cyc(3 * PK_CYC);
    rd_chk(lal_pkg::A_PEAK, 32'hc8);
    rd_chk(lal_pkg::A_CUR_PK, 32'h23);
    rd_chk(lal_pkg::A_UDC_PK, 32'h223);
    rd_chk(lal_pkg::A_FREQ_PK, 32'h32);
    rd_chk(lal_pkg::A_PEAK_TIME, 32'h321);
    rd_chk(lal_pkg::A_PEAK_DATE, 32'h1234);
  endtask : t_peak

  task automatic t_clear();
    reg_wr(lal_pkg::A_FILT, 32'h5dc);
    rd_chk(lal_pkg::A_FILT, 32'h4b0);
    wait_cyc(3 * PK_CYC);
    rd_chk(lal_pkg::A_PEAK, 32'h64);
    pk_lvl <= 16'sh0020;
    reg_wr(lal_pkg::A_SRC, 32'h7);
    rd_chk(lal_pkg::A_SRC, 32'h0);
    wait_cyc(3 * PK_CYC);
    rd_chk(lal_pkg::A_PEAK, 32'h20);
    reg_wr(lal_pkg::A_FILT, 32'h1);
    wait_cyc(2 * PK_CYC);
    pk_lvl <= 16'sh0120;
    wait_cyc(3 * PK_CYC);
    reg_rd(lal_pkg::A_PEAK, rd_val);
    check({31'h0, rd_val > 32'h20 && rd_val < 32'h60}, 32'h1);
    reg_wr(lal_pkg::A_PEAK_SEL, 32'h64);
    wait_cyc(3 * PK_CYC);
    reg_rd(lal_pkg::A_STATUS, rd_val);
    check({31'h0, rd_val[0]}, 32'h0);
    reg_wr(lal_pkg::A_FILT, 32'h0);
  endtask : t_clear

  task automatic t_din();
    logic [7:0] code;
    logic rise;
    logic [16:0] stamp;
    rtc_ok <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      for (int n = 0; n < 2; n++) begin
        code = (n == 1) ? 8'(-(p + 1)) : 8'(p + 1);
        rise = (n == 0);
        stamp = 17'h00100 + 17'(p * 4 + n * 2);
        din_set[p] <= !rise;
        reg_wr(lal_pkg::A_SRC, {{24{code[7]}}, code});
        rd_chk(lal_pkg::A_SRC, {{24{code[7]}}, code});
        rtc_time <= stamp;
        din_set[p] <= rise;
        wait_cyc(10);
        rd_chk(lal_pkg::A_RST_TIME, {15'h0, stamp});
        rtc_time <= stamp + 17'h00001;
        din_set[p] <= !rise;
        wait_cyc(10);
        rd_chk(lal_pkg::A_RST_TIME, {15'h0, stamp});
      end
    end
    rd_chk(lal_pkg::A_RST_DATE, 32'h1234);
    reg_wr(lal_pkg::A_SRC, 32'h0);
  endtask : t_din

  task automatic t_dist();
    reg_wr(lal_pkg::A_BASE, 32'hc8);
    ds_lvl <= 16'sh0096;
    reg_wr(lal_pkg::A_DIST_SEL, 32'h66);
    wait_cyc(2 * DS_CYC + 20);
    check({24'h0, ds_idx}, 32'h66);
    rd_chk({lal_pkg::PAGE_AL2, 4'h7}, 32'h64);
    rd_chk({lal_pkg::PAGE_AL2, 4'h6}, 32'h0);
    rd_chk({lal_pkg::PAGE_AL1, 4'h7}, 32'h64);
    rd_chk({lal_pkg::PAGE_AL1, 4'h6}, 32'h0);
    rtc_ok <= 1'b0;
    reg_wr(lal_pkg::A_SRC, 32'h7);
    rd_chk({lal_pkg::PAGE_AL2, 4'h7}, 32'h0);
    rd_chk({lal_pkg::PAGE_AL1, 4'h7}, 32'h64);
    rd_chk(lal_pkg::A_RST_DATE, 32'h0);
    wait_cyc(DS_CYC + 20);
    rd_chk({lal_pkg::PAGE_AL2, 4'h7}, 32'h64);
    reg_wr(lal_pkg::A_DIST_SEL, 32'h64);
    wait_cyc(2 * DS_CYC + 20);
    for (int k = 0; k < 10; k++) begin
      rd_chk({lal_pkg::PAGE_AL2, 4'(k)}, 32'h0);
    end
  endtask : t_dist

  initial begin
    wait_cyc(6);
    i_rst <= 1'b0;
    t_reset();
    t_peak();
    t_clear();
    t_din();
    t_dist();
    print_verdict();
  end
endmodule : testbench
